// ### include/srl_pkg.sv
// Package with the register map, field layout and timing constants of the set-reset latch unit.
package srl_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] SRL_OFS_CTRL0 = 4'h0;
  localparam logic [3:0] SRL_OFS_CTRL1 = 4'h4;
  localparam logic [3:0] SRL_OFS_STATUS = 4'h8;
  localparam int SRL_ADDR_W = 4;

  // Field positions in latch_control_zero.
  localparam int SRL_C0_LATCH_EN = 7;
  localparam int SRL_C0_DIV_LSB = 4;
  localparam int SRL_C0_DIV_MSB = 6;
  localparam int SRL_C0_TRUE_OE = 3;
  localparam int SRL_C0_INV_OE = 2;
  localparam int SRL_C0_SET_STB = 1;
  localparam int SRL_C0_RST_STB = 0;

  // Field positions in latch_control_one: upper nibble selects set sources, lower reset sources.
  localparam int SRL_C1_SET_LSB = 4;
  localparam int SRL_C1_SET_MSB = 7;
  localparam int SRL_C1_RST_LSB = 0;
  localparam int SRL_C1_RST_MSB = 3;

  // Field positions in the status register.
  localparam int SRL_ST_STATE = 0;
  localparam int SRL_ST_INV = 1;
  localparam int SRL_ST_SRC_LSB = 2;
  localparam int SRL_ST_SRC_MSB = 5;

  // Reset values of the writable registers.
  localparam logic [7:0] SRL_CTRL0_RST = 8'h00;
  localparam logic [7:0] SRL_CTRL1_RST = 8'h00;

  // Timing: one instruction cycle lasts four oscillator cycles; the divider spans 512 cycles.
  localparam int SRL_FOSC_PER_QCLK = 4;
  localparam logic [1:0] SRL_STB_LAST = 2'(SRL_FOSC_PER_QCLK - 1);
  localparam int SRL_DIV_W = 9;
  localparam logic [SRL_DIV_W-1:0] SRL_DIV_BASE_MASK = 9'h003;

  // AXI4-Lite response codes.
  localparam logic [1:0] SRL_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRL_RESP_SLVERR = 2'h2;

  // One bit per latch source, in register bit order.
  typedef struct packed {
    logic ext;
    logic pulse;
    logic cmp2;
    logic cmp1;
  } srl_src_t;

  // Pin drive of one latch output.
  typedef struct packed {
    logic value;
    logic oe;
  } srl_pin_t;

endpackage : srl_pkg

// ### hdl/srl_top.sv
// Set-reset latch unit with source selection, pulse divider and AXI4-Lite register access.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module srl_top
  import srl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SRL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SRL_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_latch_input,
  input wire logic cmp1_synced_out,
  input wire logic cmp2_synced_out,
  output logic true_out_pin,
  output logic true_out_pin_oe,
  output logic inverted_out_pin,
  output logic inverted_out_pin_oe
);

  // Mask of low counter bits that must all be ones for a pulse at the selected period.
  function automatic logic [SRL_DIV_W-1:0] srl_div_mask(input logic [2:0] sel);
    logic [SRL_DIV_W-1:0] m;
    m = SRL_DIV_BASE_MASK;
    for (int i = 0; i < 7; i++) begin
      if (3'(i) < sel) begin
        m = {m[SRL_DIV_W-2:0], 1'b1};
      end
    end
    return m;
  endfunction : srl_div_mask

  // Gates the four sources with their per-source enables.
  function automatic logic srl_any_src(input srl_src_t src, input srl_src_t en);
    return |(src & en);
  endfunction : srl_any_src

  // Register state.
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [1:0] set_cnt_r;
  logic [1:0] rst_cnt_r;
  logic set_stb_r;
  logic rst_stb_r;
  logic [SRL_DIV_W-1:0] div_cnt_r;
  logic pulse_r;
  srl_src_t meta_r;
  srl_src_t sync_r;
  logic latch_state;

  // AXI channel state and registered pin drive.
  logic aw_hold_r;
  logic [SRL_ADDR_W-1:0] aw_addr_r;
  logic w_hold_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  srl_pin_t true_pin_r;
  srl_pin_t inv_pin_r;

  // Named control fields.
  wire latch_enable = ctrl0_r[SRL_C0_LATCH_EN];
  wire [2:0] pulse_divider_select = ctrl0_r[SRL_C0_DIV_MSB:SRL_C0_DIV_LSB];
  wire true_out_enable = ctrl0_r[SRL_C0_TRUE_OE];
  wire inverted_out_enable = ctrl0_r[SRL_C0_INV_OE];
  wire srl_src_t set_sel = ctrl1_r[SRL_C1_SET_MSB:SRL_C1_SET_LSB];
  wire srl_src_t rst_sel = ctrl1_r[SRL_C1_RST_MSB:SRL_C1_RST_LSB];
  wire pulse_sets_enable = set_sel.pulse;
  wire pulse_resets_enable = rst_sel.pulse;

  // Bus handshake decode.
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire wr_do = aw_hold_r && w_hold_r && !bvalid_r;
  wire b_done = bvalid_r && s_axi_bready;
  wire ar_take = s_axi_arvalid && arready_r;
  wire r_done = rvalid_r && s_axi_rready;
  wire wr_ctrl0 = wr_do && w_lane0_r && (aw_addr_r == SRL_OFS_CTRL0);
  wire wr_ctrl1 = wr_do && w_lane0_r && (aw_addr_r == SRL_OFS_CTRL1);
  wire wr_known = (aw_addr_r == SRL_OFS_CTRL0) || (aw_addr_r == SRL_OFS_CTRL1)
                  || (aw_addr_r == SRL_OFS_STATUS);
  wire rd_known = (s_axi_araddr == SRL_OFS_CTRL0) || (s_axi_araddr == SRL_OFS_CTRL1)
                  || (s_axi_araddr == SRL_OFS_STATUS);
  wire set_stb_req = wr_ctrl0 && w_data_r[SRL_C0_SET_STB];
  wire rst_stb_req = wr_ctrl0 && w_data_r[SRL_C0_RST_STB];

  // Latch inputs: firmware strobes plus the enabled sources (synchronised inputs and divider pulse), gated by the enable.
  srl_src_t live_src;
  assign live_src = '{ext: sync_r.ext, pulse: pulse_r, cmp2: sync_r.cmp2, cmp1: sync_r.cmp1};
  srl_src_t set_en;
  srl_src_t rst_en;
  assign set_en = '{ext: set_sel.ext, pulse: pulse_sets_enable, cmp2: set_sel.cmp2,
                    cmp1: set_sel.cmp1};
  assign rst_en = '{ext: rst_sel.ext, pulse: pulse_resets_enable, cmp2: rst_sel.cmp2,
                    cmp1: rst_sel.cmp1};
  wire latch_set = latch_enable && (set_stb_r || srl_any_src(live_src, set_en));
  wire latch_rst = latch_enable && (rst_stb_r || srl_any_src(live_src, rst_en));

  // Read data selection.
  wire [7:0] ctrl0_view = {ctrl0_r[7:2], set_stb_r, rst_stb_r};
  wire [7:0] status_view = {2'h0, sync_r, ~latch_state, latch_state};
  wire [7:0] rd_byte = (s_axi_araddr == SRL_OFS_CTRL0) ? ctrl0_view :
                       (s_axi_araddr == SRL_OFS_CTRL1) ? ctrl1_r :
                       (s_axi_araddr == SRL_OFS_STATUS) ? status_view : 8'h00;

  // Divider pulse and output pin values.
  wire pulse_nxt = ((div_cnt_r & srl_div_mask(pulse_divider_select))
                    == srl_div_mask(pulse_divider_select));
  srl_pin_t true_pin_nxt;
  srl_pin_t inv_pin_nxt;
  assign true_pin_nxt = '{value: latch_enable && true_out_enable && latch_state,
                          oe: latch_enable && true_out_enable};
  assign inv_pin_nxt = '{value: latch_enable && inverted_out_enable && !latch_state,
                         oe: latch_enable && inverted_out_enable};

  // The latch itself: level sensitive, reset dominant, and never initialised by reset.
  always_latch begin
    if (latch_rst) begin
      latch_state = 1'b0;
    end else if (latch_set) begin
      latch_state = 1'b1;
    end
  end

  // Two-stage synchronisers for the pin and comparator inputs.
  always_ff @(posedge aclk) begin
    meta_r <= '{ext: external_latch_input, pulse: 1'b0, cmp2: cmp2_synced_out,
                cmp1: cmp1_synced_out};
    sync_r <= meta_r;
  end

  // Free-running divider; the pulse register is high for exactly one cycle per period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
      pulse_r <= pulse_nxt;
    end
  end

  // Set strobe: held for one instruction cycle, then clears itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set_stb_r <= 1'b0;
      set_cnt_r <= '0;
    end else if (set_stb_req) begin
      set_stb_r <= 1'b1;
      set_cnt_r <= '0;
    end else if (set_stb_r) begin
      set_stb_r <= (set_cnt_r != SRL_STB_LAST);
      set_cnt_r <= set_cnt_r + 1'b1;
    end
  end

  // Reset strobe: same timing as the set strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_stb_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (rst_stb_req) begin
      rst_stb_r <= 1'b1;
      rst_cnt_r <= '0;
    end else if (rst_stb_r) begin
      rst_stb_r <= (rst_cnt_r != SRL_STB_LAST);
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end
  end

  // Control registers; the strobe bits are not stored here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_r <= SRL_CTRL0_RST;
      ctrl1_r <= SRL_CTRL1_RST;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= {w_data_r[7:2], 2'h0};
      end
      if (wr_ctrl1) begin
        ctrl1_r <= w_data_r;
      end
    end
  end

  // Registered pin drive so every output leaves a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      true_pin_r <= '0;
      inv_pin_r <= '0;
    end else begin
      true_pin_r <= true_pin_nxt;
      inv_pin_r <= inv_pin_nxt;
    end
  end

  // Write address and data are captured independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      awready_r <= 1'b1;
    end else if (aw_take) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      awready_r <= 1'b0;
    end else if (wr_do) begin
      aw_hold_r <= 1'b0;
    end else if (b_done) begin
      awready_r <= 1'b1;
    end
  end

  // Write data capture; only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= '0;
      w_lane0_r <= 1'b0;
      wready_r <= 1'b1;
    end else if (w_take) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
      wready_r <= 1'b0;
    end else if (wr_do) begin
      w_hold_r <= 1'b0;
    end else if (b_done) begin
      wready_r <= 1'b1;
    end
  end

  // Write response, one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= SRL_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? SRL_RESP_OKAY : SRL_RESP_SLVERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: data is registered on the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= SRL_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_known ? SRL_RESP_OKAY : SRL_RESP_SLVERR;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // Port drives.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign true_out_pin = true_pin_r.value;
  assign true_out_pin_oe = true_pin_r.oe;
  assign inverted_out_pin = inv_pin_r.value;
  assign inverted_out_pin_oe = inv_pin_r.oe;

endmodule : srl_top

`default_nettype wire

// ### bench/srl_props.sv
// Port checker for the set-reset latch unit.
`timescale 1ns/10ps
`default_nettype none

module srl_props
  import srl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic true_out_pin,
  input wire logic true_out_pin_oe,
  input wire logic inverted_out_pin,
  input wire logic inverted_out_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both halves of a write are taken at the same edge.
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_bans; s_wtake |-> ##[1:2] s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write answer missing");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_tq; !true_out_pin_oe |-> !true_out_pin; endproperty
  a_tq: assert property (p_tq) else $error("true pin driven while off");
  property p_nq; !inverted_out_pin_oe |-> !inverted_out_pin; endproperty
  a_nq: assert property (p_nq) else $error("inverted pin driven while off");
  property p_inv; true_out_pin_oe && inverted_out_pin_oe |-> inverted_out_pin != true_out_pin;
  endproperty
  a_inv: assert property (p_inv) else $error("pins not complementary");
endmodule : srl_props

`default_nettype wire

// ### bench/srl_partner.sv
// Model of the comparators and external pin that feed the latch, and of the two output pads.
`timescale 1ns/10ps
`default_nettype none

module srl_partner (
  input wire logic [2:0] lvl,
  input wire logic [1:0] port_direction_bit,
  input wire logic [1:0] pin_value,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pad,
  output logic cmp1_synced_out,
  output logic cmp2_synced_out,
  output logic external_latch_input
);
  // Each source shows its commanded level, high meaning active.
  assign cmp1_synced_out = lvl[0];
  assign cmp2_synced_out = lvl[1];
  assign external_latch_input = lvl[2];
  // A pad shows the latch output only while its direction bit is cleared and the pin drives.
  assign pad = pin_value & pin_oe & ~port_direction_bit;
endmodule : srl_partner

`default_nettype wire

// ### bench/srl_tb_top.sv
// Self-checking bench for the set-reset latch unit.
`timescale 1ns/10ps
`default_nettype none

module srl_tb_top
  import srl_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tq, tqe, nq, nqe, c1, c2, ex;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, lows;
  logic [1:0] bresp, rresp, rs, bs;
  logic [2:0] lvl;
  logic [1:0] dirb, pad;
  logic [7:0] sb, rb;
  int mismatches, comparisons, seed, mq, men, mte, mne, b;

  srl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_latch_input(ex), .cmp1_synced_out(c1), .cmp2_synced_out(c2),
    .true_out_pin(tq), .true_out_pin_oe(tqe), .inverted_out_pin(nq),
    .inverted_out_pin_oe(nqe));
  srl_partner u_far (.lvl(lvl), .port_direction_bit(dirb), .pin_value({tq, nq}),
    .pin_oe({tqe, nqe}), .pad(pad), .cmp1_synced_out(c1), .cmp2_synced_out(c2),
    .external_latch_input(ex));

  // Free-running 100 MHz clock and a watchdog against hangs.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    close_out();
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // Write one word; the response channel is accepted after a random delay.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw, w, k;
    int dl;
    @(posedge aclk);
    dl = $random(seed) & 3;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    k = 0;
    for (int n = 0; !k; n++) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      k = bvalid && bready;
      bs = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      bready <= !k && n >= dl;
    end
  endtask : wr

  // Read one word into rv and rs, accepting the answer after a random delay.
  task automatic rd(input logic [3:0] a);
    logic ar, k;
    int dl;
    @(posedge aclk);
    dl = $random(seed) & 3;
    araddr <= a;
    arvalid <= 1'b1;
    k = 0;
    for (int n = 0; !k; n++) begin
      @(negedge aclk);
      ar = arvalid && arready;
      k = rvalid && rready;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      rready <= !k && n >= dl;
    end
  endtask : rd

  // Expected pins from the reference latch: {true oe, true, inverted oe, inverted}.
  function automatic logic [3:0] pexp();
    return {men && mte, men && mte && mq == 1, men && mne, men && mne && mq == 0};
  endfunction : pexp

  // Write control zero, update the reference latch, then compare the pins.
  task automatic c0(input logic [7:0] d);
    logic [3:0] e;
    wr(SRL_OFS_CTRL0, d);
    men = d[7];
    mte = d[3];
    mne = d[2];
    if (men && d[0]) mq = 0;
    else if (men && d[1]) mq = 1;
    tick(8);
    e = pexp();
    chk("pins", 32'(e), 32'({tqe, tq, nqe, nq}));
    chk("pads", 32'({e[2], e[0]}), 32'(pad));
  endtask : c0

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Main sequence of tests.
  initial begin
    seed = 96;
    lvl = 3'h0;
    dirb = 2'b00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SRL_OFS_CTRL0);
    chk("ctrl0 reset", 32'(SRL_CTRL0_RST), rv);
    rd(SRL_OFS_CTRL1);
    chk("ctrl1 reset", 32'(SRL_CTRL1_RST), rv);
    rd(4'hC);
    chk("unmapped rresp", 32'(SRL_RESP_SLVERR), 32'(rs));
    wr(4'hC, 8'hFF);
    chk("unmapped bresp", 32'(SRL_RESP_SLVERR), 32'(bs));
    $display("test registers done");
    c0(8'h80);
    c0(8'h82);
    rd(SRL_OFS_CTRL0);
    chk("strobe cleared", 32'h80, rv);
    rd(SRL_OFS_STATUS);
    chk("status", 32'h1, rv & 32'h3);
    c0(8'h8C);
    c0(8'h8F);
    $display("test strobes done");
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 3; k++) begin
        b = (i == 2) ? 3 : i;
        sb = 8'h10 << b;
        rb = 8'h01 << b;
        if (k == 2) c0(8'h8E);
        wr(SRL_OFS_CTRL1, k == 0 ? sb : k == 1 ? rb : sb | rb);
        lvl <= 3'(1 << i);
        tick(1 + ($random(seed) & 3));
        lvl <= 3'h0;
        mq = (k == 0);
        tick(6);
        chk("source pins", 32'(pexp()), 32'({tqe, tq, nqe, nq}));
      end
    end
    $display("test sources done");
    c0(8'h0C);
    $display("test disable done");
    lvl <= 3'h4;
    for (int i = 0; i < 9; i++) begin
      wr(SRL_OFS_CTRL1, i < 8 ? 8'h84 : 8'h80);
      wr(SRL_OFS_CTRL0, 8'h8C | 8'((i % 8) << 4));
      tick(8);
      lows = 32'h0;
      repeat (512) begin
        @(negedge aclk);
        lows = lows + 32'(!tq);
      end
      chk("pulse lows", i < 8 ? 512 >> (i + 2) : 0, lows);
    end
    lvl <= 3'h0;
    wr(SRL_OFS_CTRL1, 8'h00);
    c0(8'h8D);
    wr(SRL_OFS_CTRL1, 8'h40);
    tick(8);
    mq = 1;
    chk("pulse sets", 32'(pexp()), 32'({tqe, tq, nqe, nq}));
    $display("test divider done");
    close_out();
  end
endmodule : srl_tb_top

bind srl_top srl_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .true_out_pin(true_out_pin),
  .true_out_pin_oe(true_out_pin_oe), .inverted_out_pin(inverted_out_pin),
  .inverted_out_pin_oe(inverted_out_pin_oe));

`default_nettype wire
